// >>> rtl/calendar_rtc_with_alarm.sv
// Notes on behaviour
// - Time advances only while tick enable is 1; it resets enabled.
// - Timebase is a 32.768kHz source, crystal or general-purpose pin.
// - Control bit 15 picks binary (0) or BCD (1) coding; resets 0.
// - Control bit 14 picks 12-hour (1) or 24-hour (0); resets 0.
// - Seconds at 6:0, minutes at 14:8, each 0 to 59, reset zero.
// - Weekday at 10:8, 1 to 7, 1 is Sunday, resets 1.
// - Hours at 4:0, 5:0 in 24-hour mode; afternoon flag at bit 5 only in 12-hour mode.
// - Month at 12:8 is 1 to 12, day at 5:0 is 1 to 31; reset 1.
// - Century at 13:8 fixed at 20; year units 7:0 range 0 to 99.
// - Each seconds increment raises a seconds event; time then holds one second.
// - Control bit 11 requests the seconds counter stop; resets 0.
// - Status bit 10 reads 1 once the counter has really stopped.
// - An all-ones alarm field is excluded from the comparison.
// - All compared alarm fields equal the time: alarm event raised.
// - Alarm minutes at 14:8, seconds at 6:0, range 0 to 59, reset zero.
// - Alarm weekday is four bits at 11:8, resets zero.
// - Alarm month at 12:8, alarm day at 5:0, both reset zero.
// - The alarm event lasts as long as the compared fields match.
// - Bit 9 stops alarms, resets 1; bit 8 reads 1 while stopped.
// - Tick enable is bit 11 of power management, reset 1.
module calendar_rtc_with_alarm (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        xtal_32k,
   input  wire logic        gpio_32k,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output logic             seconds_event,
   output logic             alarm_match_event
);
   logic [6:0]  sec_q;
   logic [6:0]  min_q;
   logic [4:0]  hour_q;
   logic [2:0]  wday_q;
   logic [4:0]  date_q;
   logic [3:0]  mth_q;
   logic [6:0]  year_q;
   logic [6:0]  alm_sec_q;
   logic [6:0]  alm_min_q;
   logic [5:0]  alm_hrs_q;
   logic [3:0]  alm_wday_q;
   logic [5:0]  alm_date_q;
   logic [4:0]  alm_mth_q;
   logic        bcd_q;
   logic        half_day_q;
   logic        stop_req_q;
   logic        stopped_q;
   logic        alm_stop_req_q;
   logic        alm_stopped_q;
   logic        tick_enable_q;
   logic        src_sel_q;
   logic        aw_held_q;
   logic        w_held_q;
   logic [5:0]  wr_idx_q;
   logic [15:0] wdata_q;
   logic [1:0]  wstrb_q;
   logic [15:0] disp_sm;
   logic [15:0] disp_hd;
   logic [15:0] disp_dm;
   logic [15:0] disp_yr;
   logic [15:0] merged;
   logic [4:0]  new_hour;
   logic        wr_fire;
   logic        run;
   logic        sec_tick;
   logic        tick_apply;

   alarm_cmp_if am ();

   function automatic logic [7:0] enc(input logic [6:0] v, input logic bcd);
      logic [6:0] tens;
      tens = v / 7'd10;
      return bcd ? {tens[3:0], 4'(v % 7'd10)} : {1'b0, v};
   endfunction : enc

   function automatic logic [6:0] dec(input logic [7:0] x, input logic bcd);
      return bcd ? ({3'h0, x[7:4]} * 7'd10 + {3'h0, x[3:0]}) : x[6:0];
   endfunction : dec

   function automatic logic [4:0] days_in(input logic [3:0] m, input logic [6:0] y);
      logic [4:0] d;
      d = 5'd31;
      case (m)
         4'd2:                      d = (y[1:0] == 2'h0) ? 5'd29 : 5'd28;
         4'd4, 4'd6, 4'd9, 4'd11:   d = 5'd30;
         default:                   d = 5'd31;
      endcase
      return d;
   endfunction : days_in

   function automatic logic mapped(input logic [5:0] idx);
      return (idx >= rtc_pkg::IDX_SEC_MIN && idx <= rtc_pkg::IDX_CLK_SOURCE)
          || idx == rtc_pkg::IDX_PWR_MGMT;
   endfunction : mapped

   function automatic logic [15:0] reg_value(input logic [5:0] idx);
      logic [15:0] v;
      v = 16'h0;
      if (idx == rtc_pkg::IDX_SEC_MIN) begin
         v = disp_sm;
      end else if (idx == rtc_pkg::IDX_HRS_DAY) begin
         v = disp_hd;
      end else if (idx == rtc_pkg::IDX_DATE_MTH) begin
         v = disp_dm;
      end else if (idx == rtc_pkg::IDX_YEAR) begin
         v = disp_yr;
      end else if (idx == rtc_pkg::IDX_ALM_SEC_MIN) begin
         v[rtc_pkg::MIN_LSB +: 7] = alm_min_q;
         v[rtc_pkg::SEC_LSB +: 7] = alm_sec_q;
      end else if (idx == rtc_pkg::IDX_ALM_HRS_DAY) begin
         v[rtc_pkg::WDAY_LSB +: 4] = alm_wday_q;
         v[rtc_pkg::HRS_LSB +: 6]  = alm_hrs_q;
      end else if (idx == rtc_pkg::IDX_ALM_DATE_MTH) begin
         v[rtc_pkg::MTH_LSB +: 5]  = alm_mth_q;
         v[rtc_pkg::DATE_LSB +: 6] = alm_date_q;
      end else if (idx == rtc_pkg::IDX_CONTROL) begin
         v[rtc_pkg::BCD_BIT]          = bcd_q;
         v[rtc_pkg::HALF_DAY_BIT]     = half_day_q;
         v[rtc_pkg::STOP_REQ_BIT]     = stop_req_q;
         v[rtc_pkg::STOPPED_BIT]      = stopped_q;
         v[rtc_pkg::ALM_STOP_REQ_BIT] = alm_stop_req_q;
         v[rtc_pkg::ALM_STOPPED_BIT]  = alm_stopped_q;
      end else if (idx == rtc_pkg::IDX_PWR_MGMT) begin
         v[rtc_pkg::TICK_EN_BIT] = tick_enable_q;
      end else if (idx == rtc_pkg::IDX_CLK_SOURCE) begin
         v[rtc_pkg::SRC_SEL_BIT] = src_sel_q;
      end
      return v;
   endfunction : reg_value

   // Time is kept in binary 24-hour form; coding and hour format apply on access
   always_comb begin
      logic [4:0] h12;
      logic [7:0] h;
      h   = 8'h0;
      h12 = hour_q;
      if (hour_q == 5'h0) begin
         h12 = rtc_pkg::NOON_HOUR;
      end else if (hour_q > rtc_pkg::NOON_HOUR) begin
         h12 = hour_q - rtc_pkg::NOON_HOUR;
      end
      disp_sm = 16'h0;
      disp_hd = 16'h0;
      disp_dm = 16'h0;
      disp_yr = 16'h0;
      disp_sm[rtc_pkg::MIN_LSB +: 7] = 7'(enc(min_q, bcd_q));
      disp_sm[rtc_pkg::SEC_LSB +: 7] = 7'(enc(sec_q, bcd_q));
      disp_hd[rtc_pkg::WDAY_LSB +: 3] = wday_q;
      if (half_day_q) begin
         h = enc({2'h0, h12}, bcd_q);
         disp_hd[rtc_pkg::HRS_LSB +: 5] = h[4:0];
         disp_hd[rtc_pkg::PM_BIT] = (hour_q >= rtc_pkg::NOON_HOUR);
      end else begin
         h = enc({2'h0, hour_q}, bcd_q);
         disp_hd[rtc_pkg::HRS_LSB +: 6] = h[5:0];
      end
      disp_dm[rtc_pkg::MTH_LSB +: 5]  = 5'(enc({3'h0, mth_q}, bcd_q));
      disp_dm[rtc_pkg::DATE_LSB +: 6] = 6'(enc({2'h0, date_q}, bcd_q));
      disp_yr[rtc_pkg::YCENT_LSB +: 6] = 6'(enc(rtc_pkg::YEAR_CENTURY, bcd_q));
      disp_yr[rtc_pkg::YUNIT_LSB +: 8] = enc(year_q, bcd_q);
   end

   assign wr_fire = aw_held_q && w_held_q && !bvalid;
   // A process, so the merge follows the live register view
   always_comb begin
      merged = (reg_value(wr_idx_q) & ~{{8{wstrb_q[1]}}, {8{wstrb_q[0]}}})
             | (wdata_q & {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}});
   end

   always_comb begin
      logic [6:0] h;
      h = dec({3'h0, merged[4:0]}, bcd_q);
      new_hour = h[4:0];
      if (!half_day_q) begin
         h = dec({2'h0, merged[5:0]}, bcd_q);
         new_hour = h[4:0];
      end else if (h[4:0] == rtc_pkg::NOON_HOUR) begin
         new_hour = merged[rtc_pkg::PM_BIT] ? rtc_pkg::NOON_HOUR : 5'h0;
      end else if (merged[rtc_pkg::PM_BIT]) begin
         new_hour = h[4:0] + rtc_pkg::NOON_HOUR;
      end
   end

   assign run = tick_enable_q && !stop_req_q;
   assign tick_apply = sec_tick && run;

   rtc_tick_gen u_tick (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .src_32k     (src_sel_q ? gpio_32k : xtal_32k),
      .run         (run),
      .second_tick (sec_tick)
   );

   // A write to a time register wins over a tick in the same cycle; software stops first anyway
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sec_q  <= 7'h0;
         min_q  <= 7'h0;
         hour_q <= 5'h0;
         wday_q <= rtc_pkg::WDAY_RESET;
         date_q <= rtc_pkg::DATE_RESET;
         mth_q  <= rtc_pkg::MONTH_RESET;
         year_q <= 7'h0;
      end else if (wr_fire && wr_idx_q == rtc_pkg::IDX_SEC_MIN) begin
         sec_q <= dec({1'b0, merged[rtc_pkg::SEC_LSB +: 7]}, bcd_q);
         min_q <= dec({1'b0, merged[rtc_pkg::MIN_LSB +: 7]}, bcd_q);
      end else if (wr_fire && wr_idx_q == rtc_pkg::IDX_HRS_DAY) begin
         hour_q <= new_hour;
         wday_q <= merged[rtc_pkg::WDAY_LSB +: 3];
      end else if (wr_fire && wr_idx_q == rtc_pkg::IDX_DATE_MTH) begin
         date_q <= 5'(dec({2'h0, merged[rtc_pkg::DATE_LSB +: 6]}, bcd_q));
         mth_q  <= 4'(dec({3'h0, merged[rtc_pkg::MTH_LSB +: 5]}, bcd_q));
      end else if (wr_fire && wr_idx_q == rtc_pkg::IDX_YEAR) begin
         year_q <= dec(merged[rtc_pkg::YUNIT_LSB +: 8], bcd_q);
      end else if (tick_apply) begin
         if (sec_q < rtc_pkg::MAX_SEC) begin
            sec_q <= sec_q + 7'h1;
         end else begin
            sec_q <= 7'h0;
            if (min_q < rtc_pkg::MAX_SEC) begin
               min_q <= min_q + 7'h1;
            end else begin
               min_q <= 7'h0;
               if (hour_q < rtc_pkg::MAX_HOUR) begin
                  hour_q <= hour_q + 5'h1;
               end else begin
                  hour_q <= 5'h0;
                  wday_q <= (wday_q >= rtc_pkg::LAST_WDAY) ? rtc_pkg::WDAY_RESET
                                                           : wday_q + 3'h1;
                  if (date_q < days_in(mth_q, year_q)) begin
                     date_q <= date_q + 5'h1;
                  end else begin
                     date_q <= rtc_pkg::DATE_RESET;
                     if (mth_q < rtc_pkg::MAX_MONTH) begin
                        mth_q <= mth_q + 4'h1;
                     end else begin
                        mth_q  <= rtc_pkg::MONTH_RESET;
                        year_q <= (year_q >= rtc_pkg::MAX_YEAR) ? 7'h0
                                                                : year_q + 7'h1;
                     end
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alm_sec_q  <= 7'h0;
         alm_min_q  <= 7'h0;
         alm_hrs_q  <= 6'h0;
         alm_wday_q <= 4'h0;
         alm_date_q <= 6'h0;
         alm_mth_q  <= 5'h0;
      end else if (wr_fire && wr_idx_q == rtc_pkg::IDX_ALM_SEC_MIN) begin
         alm_sec_q <= merged[rtc_pkg::SEC_LSB +: 7];
         alm_min_q <= merged[rtc_pkg::MIN_LSB +: 7];
      end else if (wr_fire && wr_idx_q == rtc_pkg::IDX_ALM_HRS_DAY) begin
         alm_hrs_q  <= merged[rtc_pkg::HRS_LSB +: 6];
         alm_wday_q <= merged[rtc_pkg::WDAY_LSB +: 4];
      end else if (wr_fire && wr_idx_q == rtc_pkg::IDX_ALM_DATE_MTH) begin
         alm_date_q <= merged[rtc_pkg::DATE_LSB +: 6];
         alm_mth_q  <= merged[rtc_pkg::MTH_LSB +: 5];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bcd_q          <= 1'b0;
         half_day_q     <= 1'b0;
         stop_req_q     <= 1'b0;
         alm_stop_req_q <= rtc_pkg::ALM_STOP_RESET;
         tick_enable_q  <= rtc_pkg::TICK_EN_RESET;
         src_sel_q      <= 1'b0;
      end else if (wr_fire && wr_idx_q == rtc_pkg::IDX_CONTROL) begin
         bcd_q          <= merged[rtc_pkg::BCD_BIT];
         half_day_q     <= merged[rtc_pkg::HALF_DAY_BIT];
         stop_req_q     <= merged[rtc_pkg::STOP_REQ_BIT];
         alm_stop_req_q <= merged[rtc_pkg::ALM_STOP_REQ_BIT];
      end else if (wr_fire && wr_idx_q == rtc_pkg::IDX_PWR_MGMT) begin
         tick_enable_q  <= merged[rtc_pkg::TICK_EN_BIT];
      end else if (wr_fire && wr_idx_q == rtc_pkg::IDX_CLK_SOURCE) begin
         src_sel_q      <= merged[rtc_pkg::SRC_SEL_BIT];
      end
   end

   // Status trails the request by one cycle; no tick lands once it reads 1
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stopped_q     <= 1'b0;
         alm_stopped_q <= rtc_pkg::ALM_STOP_RESET;
      end else begin
         stopped_q     <= stop_req_q;
         alm_stopped_q <= alm_stop_req_q;
      end
   end

   assign am.t_sec  = disp_sm[rtc_pkg::SEC_LSB +: 7];
   assign am.t_min  = disp_sm[rtc_pkg::MIN_LSB +: 7];
   assign am.t_hrs  = disp_hd[rtc_pkg::HRS_LSB +: 6];
   assign am.t_wday = disp_hd[rtc_pkg::WDAY_LSB +: 4];
   assign am.t_date = disp_dm[rtc_pkg::DATE_LSB +: 6];
   assign am.t_mth  = disp_dm[rtc_pkg::MTH_LSB +: 5];
   assign am.a_sec  = alm_sec_q;
   assign am.a_min  = alm_min_q;
   assign am.a_hrs  = alm_hrs_q;
   assign am.a_wday = alm_wday_q;
   assign am.a_date = alm_date_q;
   assign am.a_mth  = alm_mth_q;

   rtc_alarm_match u_alarm (
      .cmp (am.cmp)
   );

   // Level output: held for as long as the fields match
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seconds_event     <= 1'b0;
         alarm_match_event <= 1'b0;
      end else begin
         seconds_event     <= tick_apply;
         alarm_match_event <= am.match && !alm_stop_req_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awready   <= 1'b0;
         wr_idx_q  <= 6'h0;
      end else if (awvalid && awready) begin
         aw_held_q <= 1'b1;
         awready   <= 1'b0;
         wr_idx_q  <= awaddr[7:2];
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end else begin
         awready   <= !aw_held_q && !bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wready   <= 1'b0;
         wdata_q  <= 16'h0;
         wstrb_q  <= 2'h0;
      end else if (wvalid && wready) begin
         w_held_q <= 1'b1;
         wready   <= 1'b0;
         wdata_q  <= wdata[15:0];
         wstrb_q  <= wstrb[1:0];
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end else begin
         wready   <= !w_held_q && !bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= rtc_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp  <= mapped(wr_idx_q) ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= rtc_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= {16'h0, reg_value(araddr[7:2])};
         rresp   <= mapped(araddr[7:2]) ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
      end else begin
         arready <= !rvalid;
      end
   end
endmodule : calendar_rtc_with_alarm

// >>> pkg/rtc_pkg.sv
package rtc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_PWR_MGMT     = 6'h0c;
   localparam logic [5:0] IDX_SEC_MIN      = 6'h10;
   localparam logic [5:0] IDX_HRS_DAY      = 6'h11;
   localparam logic [5:0] IDX_DATE_MTH     = 6'h12;
   localparam logic [5:0] IDX_YEAR         = 6'h13;
   localparam logic [5:0] IDX_ALM_SEC_MIN  = 6'h14;
   localparam logic [5:0] IDX_ALM_HRS_DAY  = 6'h15;
   localparam logic [5:0] IDX_ALM_DATE_MTH = 6'h16;
   localparam logic [5:0] IDX_CONTROL      = 6'h17;
   localparam logic [5:0] IDX_CLK_SOURCE   = 6'h18;

   // Control, power-management and clock-source bit positions
   localparam int BCD_BIT           = 15;
   localparam int HALF_DAY_BIT      = 14;
   localparam int STOP_REQ_BIT      = 11;
   localparam int STOPPED_BIT       = 10;
   localparam int ALM_STOP_REQ_BIT  = 9;
   localparam int ALM_STOPPED_BIT   = 8;
   localparam int TICK_EN_BIT       = 11;
   localparam int SRC_SEL_BIT       = 0;

   // Field positions
   localparam int SEC_LSB   = 0;
   localparam int MIN_LSB   = 8;
   localparam int HRS_LSB   = 0;
   localparam int PM_BIT    = 5;
   localparam int WDAY_LSB  = 8;
   localparam int DATE_LSB  = 0;
   localparam int MTH_LSB   = 8;
   localparam int YCENT_LSB = 8;
   localparam int YUNIT_LSB = 0;

   // Reset values and ranges
   localparam logic [2:0] WDAY_RESET     = 3'h1;
   localparam logic [4:0] DATE_RESET     = 5'h01;
   localparam logic [3:0] MONTH_RESET    = 4'h1;
   localparam logic [6:0] YEAR_CENTURY   = 7'h14;
   localparam logic       TICK_EN_RESET  = 1'b1;
   localparam logic       ALM_STOP_RESET = 1'b1;
   localparam logic [6:0] MAX_SEC        = 7'h3b;
   localparam logic [4:0] MAX_HOUR       = 5'h17;
   localparam logic [4:0] NOON_HOUR      = 5'h0c;
   localparam logic [2:0] LAST_WDAY      = 3'h7;
   localparam logic [3:0] MAX_MONTH      = 4'hc;
   localparam logic [6:0] MAX_YEAR       = 7'h63;

   // Source clock: one second is this many source edges
   localparam int          SRC_FREQ_HZ   = 32768;
   localparam int          SRC_PER_SEC   = SRC_FREQ_HZ * 1;
   localparam logic [14:0] SRC_LAST      = 15'(SRC_PER_SEC - 1);

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : rtc_pkg

// >>> pkg/alarm_cmp_if.sv
interface alarm_cmp_if;
   logic [6:0] t_sec;
   logic [6:0] t_min;
   logic [5:0] t_hrs;
   logic [3:0] t_wday;
   logic [5:0] t_date;
   logic [4:0] t_mth;
   logic [6:0] a_sec;
   logic [6:0] a_min;
   logic [5:0] a_hrs;
   logic [3:0] a_wday;
   logic [5:0] a_date;
   logic [4:0] a_mth;
   logic       match;

   modport owner (output t_sec, t_min, t_hrs, t_wday, t_date, t_mth,
                  output a_sec, a_min, a_hrs, a_wday, a_date, a_mth,
                  input  match);
   modport cmp   (input  t_sec, t_min, t_hrs, t_wday, t_date, t_mth,
                  input  a_sec, a_min, a_hrs, a_wday, a_date, a_mth,
                  output match);
endinterface : alarm_cmp_if

// >>> rtl/rtc_tick_gen.sv
module rtc_tick_gen (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic src_32k,
   input  wire logic run,
   output logic      second_tick
);
   logic        src_prev_q;
   logic [14:0] edge_cnt_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_prev_q <= 1'b0;
      end else begin
         src_prev_q <= src_32k;
      end
   end

   // Held in reset while halted so a resumed second is a full second
   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         edge_cnt_q  <= 15'h0;
         second_tick <= 1'b0;
      end else if (src_32k && !src_prev_q) begin
         if (edge_cnt_q == rtc_pkg::SRC_LAST) begin
            edge_cnt_q  <= 15'h0;
            second_tick <= 1'b1;
         end else begin
            edge_cnt_q  <= edge_cnt_q + 15'h1;
            second_tick <= 1'b0;
         end
      end else begin
         second_tick <= 1'b0;
      end
   end
endmodule : rtc_tick_gen

// >>> rtl/rtc_alarm_match.sv
module rtc_alarm_match (
   alarm_cmp_if.cmp cmp
);
   function automatic logic field_ok(input logic [6:0] t,
                                     input logic [6:0] a,
                                     input logic [6:0] ones);
      return (a == ones) || (a == t);
   endfunction : field_ok

   logic hrs_ok;

   // An all-ones hours field also masks the afternoon bit
   always_comb begin
      hrs_ok = (cmp.a_hrs[4:0] == 5'h1f) || (cmp.a_hrs == cmp.t_hrs);
      cmp.match = hrs_ok
         && field_ok(cmp.t_sec, cmp.a_sec, 7'h7f)
         && field_ok(cmp.t_min, cmp.a_min, 7'h7f)
         && field_ok({3'h0, cmp.t_wday}, {3'h0, cmp.a_wday}, 7'h0f)
         && field_ok({1'h0, cmp.t_date}, {1'h0, cmp.a_date}, 7'h3f)
         && field_ok({2'h0, cmp.t_mth}, {2'h0, cmp.a_mth}, 7'h1f);
   end
endmodule : rtc_alarm_match

// >>> testbench/xtal_32k_model.sv
module xtal_32k_model (
   output logic clk_32k
);
   timeunit 1ns;
   timeprecision 1ps;
   // Free running like the real crystal, so no tick lands in this short run
   initial clk_32k = 1'b0;
   always #15258.789 clk_32k = ~clk_32k;
endmodule : xtal_32k_model

// >>> testbench/rtc_chk.sv
module rtc_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  awaddr,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0]  wstrb,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic [7:0]  araddr,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0]  rresp,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic        seconds_event,
   input wire logic        alarm_match_event
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence aw_w_take;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence alarm_stop_write;
      aw_w_take ##0 (awaddr == 8'h5c && wstrb[1] && wdata[9]);
   endsequence
   AST_SEC_PULSE: assert property (seconds_event |=> !seconds_event)
      else $error("seconds event longer than one cycle");
   AST_ALM_STOP: assert property (alarm_stop_write |-> ##4 !alarm_match_event [*3])
      else $error("alarm event while alarms stopped");
   AST_B_ANSWER: assert property (aw_w_take |-> ##[1:3] bvalid)
      else $error("write response missing");
   AST_AW_REFUSE: assert property (aw_w_take |=> !awready [*2] ##0 !wready)
      else $error("write taken again too early");
   AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   AST_R_UPPER: assert property (rvalid |-> rdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   AST_UNMAPPED: assert property (arvalid && arready && araddr[7:2] > 6'h18
      |-> ##[1:2] (rvalid && rresp == 2'h2 && rdata == 32'h0))
      else $error("unmapped read not refused");
   AST_RESET_IDLE: assert property (disable iff (1'b0) !aresetn
      |=> !bvalid && !rvalid && !seconds_event && !alarm_match_event)
      else $error("outputs active after reset");
endmodule : rtc_chk
bind calendar_rtc_with_alarm rtc_chk rtc_chk_inst (.*);

// >>> testbench/tb.sv
`define CHK(g, e) begin checks++; if ((g) !== (e)) mismatch(32'(g), 32'(e)); end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0, aresetn = 1'b0, gpio_32k = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, last_rd;
   logic [3:0]  wstrb = 4'h0;
   logic        xtal_32k, awready, wready, bvalid, arready, rvalid;
   logic        seconds_event, alarm_match_event;
   logic [1:0]  bresp, rresp, last_resp;
   int          failures = 0;
   int          checks = 0;

   xtal_32k_model xtal_32k_model_inst (.clk_32k(xtal_32k));
   calendar_rtc_with_alarm calendar_rtc_with_alarm_inst (.*);

   always #20 aclk = ~aclk;

   task automatic tally_and_finish;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish

   task automatic mismatch(input logic [31:0] g, input logic [31:0] e);
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
   endtask : mismatch

   task automatic hang(input int n, input int lim = 40);
      if (n > lim) begin
         failures++;
         tally_and_finish;
      end
   endtask : hang

   // Both write channels offered together; bready held until the answer
   task automatic wr(input logic [5:0] idx, input logic [15:0] d);
      int n;
      n = 0;
      awaddr <= {idx, 2'b00};
      wdata <= {16'h0, d};
      wstrb <= 4'h3;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bready && bvalid) begin
            last_resp = bresp;
            bready <= 1'b0;
         end
         n++;
         hang(n);
      end while (awvalid || wvalid || bready);
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [5:0] idx);
      int n;
      n = 0;
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rready && rvalid) begin
            last_rd = rdata;
            last_resp = rresp;
            rready <= 1'b0;
         end
         n++;
         hang(n);
      end while (arvalid || rready);
      @(posedge aclk);
   endtask : rd

   task automatic rdc(input logic [5:0] idx, input logic [15:0] e);
      rd(idx);
      `CHK(last_resp, rtc_pkg::RESP_OKAY)
      `CHK(last_rd, {16'h0, e})
   endtask : rdc

   task automatic reset_values;
      rdc(rtc_pkg::IDX_SEC_MIN, 16'h0000);
      rdc(rtc_pkg::IDX_HRS_DAY, 16'h0100);
      rdc(rtc_pkg::IDX_DATE_MTH, 16'h0101);
      rdc(rtc_pkg::IDX_YEAR, 16'h1400);
      rdc(rtc_pkg::IDX_ALM_SEC_MIN, 16'h0000);
      rdc(rtc_pkg::IDX_ALM_HRS_DAY, 16'h0000);
      rdc(rtc_pkg::IDX_ALM_DATE_MTH, 16'h0000);
      rdc(rtc_pkg::IDX_CONTROL, 16'h0300);
      rdc(rtc_pkg::IDX_PWR_MGMT, 16'h0800);
   endtask : reset_values

   task automatic set_time;
      wr(rtc_pkg::IDX_CONTROL, 16'h0a00);
      rdc(rtc_pkg::IDX_CONTROL, 16'h0f00);
      wr(rtc_pkg::IDX_SEC_MIN, 16'h3b3b);
      wr(rtc_pkg::IDX_HRS_DAY, 16'h0517);
      wr(rtc_pkg::IDX_YEAR, 16'hff63);
      rdc(rtc_pkg::IDX_SEC_MIN, 16'h3b3b);
      rdc(rtc_pkg::IDX_HRS_DAY, 16'h0517);
      rdc(rtc_pkg::IDX_YEAR, 16'h1463);
      wr(rtc_pkg::IDX_CONTROL, 16'h8a00);
      rdc(rtc_pkg::IDX_SEC_MIN, 16'h5959);
      wr(rtc_pkg::IDX_CONTROL, 16'h4a00);
      rdc(rtc_pkg::IDX_HRS_DAY, 16'h052b);
   endtask : set_time

   task automatic alarm_match;
      wr(rtc_pkg::IDX_CONTROL, 16'h0a00);
      wr(rtc_pkg::IDX_ALM_SEC_MIN, 16'h3b3b);
      wr(rtc_pkg::IDX_ALM_HRS_DAY, 16'h053f);
      wr(rtc_pkg::IDX_ALM_DATE_MTH, 16'h1f3f);
      `CHK(alarm_match_event, 1'b0)
      wr(rtc_pkg::IDX_CONTROL, 16'h0800);
      `CHK(alarm_match_event, 1'b1)
      rdc(rtc_pkg::IDX_CONTROL, 16'h0c00);
      wr(rtc_pkg::IDX_ALM_SEC_MIN, 16'h3b7f);
      `CHK(alarm_match_event, 1'b1)
      wr(rtc_pkg::IDX_ALM_HRS_DAY, 16'h013f);
      `CHK(alarm_match_event, 1'b0)
      wr(rtc_pkg::IDX_ALM_HRS_DAY, 16'h0f3f);
      `CHK(alarm_match_event, 1'b1)
      wr(rtc_pkg::IDX_CONTROL, 16'h0a00);
      `CHK(alarm_match_event, 1'b0)
   endtask : alarm_match

   task automatic bus_errors;
      rd(6'h3f);
      `CHK(last_resp, rtc_pkg::RESP_SLVERR)
      `CHK(last_rd, 32'h0)
      wr(6'h3f, 16'hffff);
      `CHK(last_resp, rtc_pkg::RESP_SLVERR)
      wr(rtc_pkg::IDX_PWR_MGMT, 16'h0000);
      rdc(rtc_pkg::IDX_PWR_MGMT, 16'h0000);
      wr(rtc_pkg::IDX_CONTROL, 16'h0200);
      rdc(rtc_pkg::IDX_CONTROL, 16'h0300);
   endtask : bus_errors

   // Pin source toggled every clock: one second is two clocks per source edge
   task automatic tick_roll;
      int n;
      n = 0;
      wr(rtc_pkg::IDX_CLK_SOURCE, 16'h0001);
      wr(rtc_pkg::IDX_PWR_MGMT, 16'h0800);
      while (!seconds_event) begin
         @(posedge aclk);
         gpio_32k <= ~gpio_32k;
         n++;
         hang(n, 70000);
      end
      `CHK(n, 2 * rtc_pkg::SRC_PER_SEC + 2)
      rdc(rtc_pkg::IDX_SEC_MIN, 16'h0000);
      rdc(rtc_pkg::IDX_SEC_MIN, 16'h0000);
      rdc(rtc_pkg::IDX_HRS_DAY, 16'h0600);
      rdc(rtc_pkg::IDX_DATE_MTH, 16'h0102);
   endtask : tick_roll

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      reset_values;
      set_time;
      alarm_match;
      bus_errors;
      tick_roll;
      tally_and_finish;
   end
endmodule : tb
